// file: inc/tro_pkg.sv
// Purpose: Shared constants and carriers for the temperature readout and log map.
// Assumes: Byte-wide register port with a 12-bit byte address.
// Notes: Histogram bins of both kinds share one counter array indexed by bin number.
package tro_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int CODE_W = 8;
	localparam int CNT_W = 16;
	localparam int BIN_W = 7;
	localparam logic [ADDR_W-1:0] OFS_CUR_TEMP = 12'h011;
	localparam logic [ADDR_W-1:0] OFS_STATUS1 = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_CUR_ADC1 = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_CUR_ADC3 = 12'h022;
	localparam logic [ADDR_W-1:0] OFS_CONTROL2 = 12'h029;
	localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'h030;
	localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 12'h031;
	localparam logic [ADDR_W-1:0] OFS_INT_CLEAR = 12'h032;
	localparam logic [ADDR_W-1:0] OFS_ALARM_BASE = 12'h220;
	localparam logic [ADDR_W-1:0] OFS_ALARM_LAST = 12'h27f;
	localparam logic [ADDR_W-1:0] OFS_HIST_BASE = 12'h800;
	localparam logic [ADDR_W-1:0] OFS_HIST_LAST = 12'h8ff;
	localparam int ALARM_RECORDS = 24;
	localparam int ALARM_BYTES = 4;
	localparam int HIST_BINS = 128;
	localparam logic [BIN_W-1:0] ADC_BIN_BASE = 7'h40;
	localparam int BIN_SHIFT = 2;
	localparam logic [CODE_W-1:0] TEMP_CODE_MAX = 8'hfa;
	localparam logic [DATA_W-1:0] TEMP_OFF_VALUE = 8'hff;
	localparam logic [DATA_W-1:0] ADC_OFF_VALUE = 8'h00;
	localparam int STATUS1_READY_BIT = 7;
	localparam int STATUS1_MISSION_BIT = 5;
	localparam int CTRL2_CS_LSB = 3;
	localparam logic [DATA_W-1:0] CTRL2_WRITE_MASK = 8'h7e;
	localparam logic [DATA_W-1:0] CTRL2_RESET = 8'h00;
	localparam int EV_CONV_DONE = 0;
	localparam int EV_RESP_DONE = 1;
	localparam int EV_CMD_REFUSED = 2;
	localparam int EV_HIST_SAT = 3;
	localparam int EV_W = 4;
	localparam logic [EV_W-1:0] EV_RESET = 4'h0;

	typedef struct packed {
		logic valid;
		logic [4:0] index;
		logic [23:0] sample_count;
		logic [7:0] duration;
	} tro_alarm_rec_type;

	typedef struct packed {
		logic valid;
		logic [1:0] channel;
		logic [CODE_W-1:0] code;
	} tro_adc_sample_type;

	typedef struct packed {
		logic valid;
		logic [1:0] channel;
		logic [DATA_W-1:0] data;
	} tro_resp_type;

	typedef enum logic [1:0] {
		TRO_IDLE = 2'b00,
		TRO_CONV = 2'b01,
		TRO_RESP = 2'b11
	} tro_state_type;
endpackage

// file: design/tro_hist.sv
// Purpose: Histogram counter array with a single-cycle saturating increment port.
// Assumes: At most one increment per cycle; the caller serialises sources.
// Notes: The read port is combinational so the caller can register it.
`timescale 1ns/1ps
`default_nettype none
module tro_hist #(
	parameter int BINS = tro_pkg::HIST_BINS,
	parameter int CNT_W = tro_pkg::CNT_W
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_inc_valid,
	input wire logic [tro_pkg::BIN_W-1:0] i_inc_bin,
	input wire logic [tro_pkg::BIN_W-1:0] i_rd_bin,
	output logic [CNT_W-1:0] o_rd_data,
	output logic o_saturated
);
	logic [CNT_W-1:0] count_q [BINS];
	logic sat_q;

	// Counters stop at all ones so a long mission never wraps a bin to a small value.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < BINS; i++) begin
				count_q[i] <= '0;
			end
		end else if (i_inc_valid && (count_q[i_inc_bin] != {CNT_W{1'b1}})) begin
			count_q[i_inc_bin] <= count_q[i_inc_bin] + CNT_W'(1);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sat_q <= 1'b0;
		end else begin
			sat_q <= i_inc_valid && (count_q[i_inc_bin] == {CNT_W{1'b1}});
		end
	end

	assign o_rd_data = count_q[i_rd_bin];
	assign o_saturated = sat_q;
endmodule // tro_hist
`default_nettype wire

// file: design/tro_top.sv
// Purpose: Temperature readout, data-ready flag, read-data response and log memory map.
// Assumes: Converter, ADC, mission sequencer and alarm logic sit on the same clock.
// Notes: Registers are byte wide on a plain strobe port with read data one cycle later.
// Summary of operation
// - Thermal sensor is enabled and converted only while the temperature select bit is set.
// - With temperature disabled the current-temperature byte holds all ones.
// - Temperature byte is half-degree steps from minus forty, clipped at the top code.
// - Host read-data outside a mission with temperature on starts a conversion at once.
// - Every new temperature result, logged or commanded, updates the current byte.
// - In a mission data-ready clears at conversion start and sets at completion.
// - An accepted read-data command clears data-ready; completion of its conversion sets it.
// - Read-data response carries only bytes of enabled channels, in channel order.
// - Twenty-four four-byte alarm records, counter low byte first, at 220h to 27Fh.
// - Temperature bins are two-byte counters from 800h, four codes per bin.
// - ADC channel 1 bins group four consecutive codes each, from 00h to FFh.
`timescale 1ns/1ps
`default_nettype none
module tro_top (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [tro_pkg::ADDR_W-1:0] i_addr,
	input wire logic [tro_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [tro_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_mission_active,
	input wire logic i_log_sample,
	input wire logic i_read_cmd,
	output logic o_temp_sensor_en,
	output logic o_temp_conv_start,
	input wire logic i_temp_conv_done,
	input wire logic [tro_pkg::CODE_W-1:0] i_temp_code,
	input wire tro_pkg::tro_adc_sample_type i_adc_sample,
	input wire tro_pkg::tro_alarm_rec_type i_alarm_rec,
	output tro_pkg::tro_resp_type o_resp,
	input wire logic i_resp_ready,
	output logic o_resp_last,
	output logic o_busy,
	output logic o_irq
);
	localparam int AL_DEPTH = tro_pkg::ALARM_RECORDS * tro_pkg::ALARM_BYTES;

	tro_pkg::tro_state_type state_q;
	logic from_cmd_q;
	logic [tro_pkg::DATA_W-1:0] ctrl2_q;
	logic [3:0] cs;
	logic [tro_pkg::DATA_W-1:0] cur_temp_q;
	logic [tro_pkg::DATA_W-1:0] cur_adc_q [3];
	logic ready_q;
	logic start_q;
	logic [1:0] resp_ch_q;
	logic resp_has_q;
	tro_pkg::tro_resp_type resp_q;
	logic [tro_pkg::DATA_W-1:0] alarm_q [AL_DEPTH];
	logic [tro_pkg::EV_W-1:0] ev_status_q;
	logic [tro_pkg::EV_W-1:0] ev_enable_q;
	logic [tro_pkg::EV_W-1:0] ev_set;
	logic [tro_pkg::DATA_W-1:0] rdata_q;
	logic adc_pend_q;
	logic [tro_pkg::BIN_W-1:0] adc_bin_q;
	logic hist_inc;
	logic [tro_pkg::BIN_W-1:0] hist_bin;
	logic [tro_pkg::CNT_W-1:0] hist_rd_data;
	logic hist_sat;
	logic temp_done;
	logic [tro_pkg::CODE_W-1:0] temp_clip;
	logic log_start;
	logic cmd_ok;
	logic cmd_refused;
	logic resp_fire;
	logic [2:0] next_ch;
	logic al_hit;
	logic [6:0] al_ofs;

	// Returns the first enabled channel at or above the given one, or 4 when none remains.
	function automatic logic [2:0] first_enabled(input logic [3:0] sel, input logic [2:0] from);
		logic [2:0] found;
		found = 3'h4;
		for (int i = 3; i >= 0; i--) begin
			if ((3'(i) >= from) && sel[i]) begin
				found = 3'(i);
			end
		end
		return found;
	endfunction

	// Maps a sample code to its bin: four consecutive codes share one counter.
	function automatic logic [tro_pkg::BIN_W-1:0] code_to_bin(input logic [tro_pkg::CODE_W-1:0] code);
		return tro_pkg::BIN_W'(code >> tro_pkg::BIN_SHIFT);
	endfunction

	// Bit 0 is the temperature channel, bits 1 to 3 the ADC channels.
	assign cs = {ctrl2_q[tro_pkg::CTRL2_CS_LSB], ctrl2_q[tro_pkg::CTRL2_CS_LSB+1],
		ctrl2_q[tro_pkg::CTRL2_CS_LSB+2], ctrl2_q[tro_pkg::CTRL2_CS_LSB+3]};

	assign o_temp_sensor_en = cs[0];
	assign temp_clip = (i_temp_code > tro_pkg::TEMP_CODE_MAX) ? tro_pkg::TEMP_CODE_MAX : i_temp_code;
	assign temp_done = (state_q == tro_pkg::TRO_CONV) && i_temp_conv_done;
	assign log_start = (state_q == tro_pkg::TRO_IDLE) && i_mission_active && i_log_sample && cs[0];
	assign cmd_ok = (state_q == tro_pkg::TRO_IDLE) && !i_mission_active && i_read_cmd && !log_start;
	assign cmd_refused = i_read_cmd && !cmd_ok;
	assign resp_fire = resp_q.valid && i_resp_ready;
	assign next_ch = first_enabled(cs, 3'({1'b0, resp_ch_q}) + 3'h1);

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q <= tro_pkg::TRO_IDLE;
			from_cmd_q <= 1'b0;
		end else begin
			case (state_q)
				tro_pkg::TRO_IDLE: begin
					if (log_start) begin
						state_q <= tro_pkg::TRO_CONV;
						from_cmd_q <= 1'b0;
					end else if (cmd_ok && cs[0]) begin
						state_q <= tro_pkg::TRO_CONV;
						from_cmd_q <= 1'b1;
					end else if (cmd_ok) begin
						state_q <= tro_pkg::TRO_RESP;
						from_cmd_q <= 1'b1;
					end
				end
				tro_pkg::TRO_CONV: begin
					if (i_temp_conv_done) begin
						state_q <= from_cmd_q ? tro_pkg::TRO_RESP : tro_pkg::TRO_IDLE;
					end
				end
				tro_pkg::TRO_RESP: begin
					if (!resp_has_q || (resp_fire && o_resp_last)) begin
						state_q <= tro_pkg::TRO_IDLE;
						from_cmd_q <= 1'b0;
					end
				end
				default: begin
					state_q <= tro_pkg::TRO_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			start_q <= 1'b0;
		end else begin
			start_q <= log_start || (cmd_ok && cs[0]);
		end
	end

	assign o_temp_conv_start = start_q;
	assign o_busy = (state_q != tro_pkg::TRO_IDLE);

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ready_q <= 1'b0;
		end else if (temp_done) begin
			ready_q <= 1'b1;
		end else if (log_start || cmd_ok) begin
			ready_q <= 1'b0;
		end else if ((state_q == tro_pkg::TRO_RESP) && !cs[0]) begin
			ready_q <= 1'b1;
		end else if ((state_q == tro_pkg::TRO_IDLE) && !ready_q && !cs[0]) begin
			ready_q <= 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cur_temp_q <= tro_pkg::TEMP_OFF_VALUE;
		end else if (!cs[0]) begin
			cur_temp_q <= tro_pkg::TEMP_OFF_VALUE;
		end else if (temp_done) begin
			cur_temp_q <= temp_clip;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < 3; i++) begin
				cur_adc_q[i] <= tro_pkg::ADC_OFF_VALUE;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (!cs[i+1]) begin
					cur_adc_q[i] <= tro_pkg::ADC_OFF_VALUE;
				end else if (i_adc_sample.valid && (i_adc_sample.channel == 2'(i + 1))) begin
					cur_adc_q[i] <= i_adc_sample.code;
				end
			end
		end
	end

	// Response stream walks the channels in select-bit order and skips disabled ones.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			resp_q <= '0;
			resp_ch_q <= 2'h0;
			resp_has_q <= 1'b0;
		end else if ((state_q != tro_pkg::TRO_RESP) && (state_q_next_is_resp())) begin
			resp_has_q <= (first_enabled(cs, 3'h0) != 3'h4);
			resp_ch_q <= 2'(first_enabled(cs, 3'h0));
			resp_q.valid <= (first_enabled(cs, 3'h0) != 3'h4);
			resp_q.channel <= 2'(first_enabled(cs, 3'h0));
			resp_q.data <= channel_byte(2'(first_enabled(cs, 3'h0)));
		end else if (resp_fire) begin
			if (o_resp_last) begin
				resp_q <= '0;
				resp_has_q <= 1'b0;
			end else begin
				resp_ch_q <= 2'(next_ch);
				resp_q.channel <= 2'(next_ch);
				resp_q.data <= channel_byte(2'(next_ch));
			end
		end
	end

	// True in the cycle before the machine enters the response phase.
	function automatic logic state_q_next_is_resp();
		return ((state_q == tro_pkg::TRO_IDLE) && cmd_ok && !cs[0]) || (temp_done && from_cmd_q);
	endfunction

	// Picks the current byte of a channel; a fresh temperature result is taken directly.
	function automatic logic [tro_pkg::DATA_W-1:0] channel_byte(input logic [1:0] ch);
		logic [tro_pkg::DATA_W-1:0] b;
		b = cur_temp_q;
		if (ch == 2'h0) begin
			b = temp_done ? temp_clip : cur_temp_q;
		end else begin
			b = cur_adc_q[ch - 2'h1];
		end
		return b;
	endfunction

	assign o_resp = resp_q;
	assign o_resp_last = resp_q.valid && (next_ch == 3'h4);

	// Alarm records are stored as four bytes: counter low, medium, high, then duration.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < AL_DEPTH; i++) begin
				alarm_q[i] <= '0;
			end
		end else if (i_alarm_rec.valid && (i_alarm_rec.index < 5'(tro_pkg::ALARM_RECORDS))) begin
			alarm_q[{i_alarm_rec.index, 2'h0}] <= i_alarm_rec.sample_count[7:0];
			alarm_q[{i_alarm_rec.index, 2'h1}] <= i_alarm_rec.sample_count[15:8];
			alarm_q[{i_alarm_rec.index, 2'h2}] <= i_alarm_rec.sample_count[23:16];
			alarm_q[{i_alarm_rec.index, 2'h3}] <= i_alarm_rec.duration;
		end
	end

	// A temperature result takes the counter port first; an ADC channel 1 sample waits one slot.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			adc_pend_q <= 1'b0;
			adc_bin_q <= '0;
		end else if (i_adc_sample.valid && (i_adc_sample.channel == 2'h1) && cs[1]) begin
			adc_pend_q <= 1'b1;
			adc_bin_q <= tro_pkg::ADC_BIN_BASE + code_to_bin(i_adc_sample.code);
		end else if (!temp_done) begin
			adc_pend_q <= 1'b0;
		end
	end

	assign hist_inc = temp_done || adc_pend_q;
	assign hist_bin = temp_done ? code_to_bin(temp_clip) : adc_bin_q;

	tro_hist #(
		.BINS(tro_pkg::HIST_BINS),
		.CNT_W(tro_pkg::CNT_W)
	) u_hist (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_inc_valid(hist_inc),
		.i_inc_bin(hist_bin),
		.i_rd_bin(i_addr[tro_pkg::BIN_W:1]),
		.o_rd_data(hist_rd_data),
		.o_saturated(hist_sat)
	);

	assign ev_set[tro_pkg::EV_CONV_DONE] = temp_done;
	assign ev_set[tro_pkg::EV_RESP_DONE] = resp_fire && o_resp_last;
	assign ev_set[tro_pkg::EV_CMD_REFUSED] = cmd_refused;
	assign ev_set[tro_pkg::EV_HIST_SAT] = hist_sat;

	// A new event in the cycle of its clear keeps the bit set.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ev_status_q <= tro_pkg::EV_RESET;
		end else if (i_wr && (i_addr == tro_pkg::OFS_INT_CLEAR)) begin
			ev_status_q <= (ev_status_q & ~i_wdata[tro_pkg::EV_W-1:0]) | ev_set;
		end else begin
			ev_status_q <= ev_status_q | ev_set;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ev_enable_q <= tro_pkg::EV_RESET;
			ctrl2_q <= tro_pkg::CTRL2_RESET;
		end else if (i_wr && (i_addr == tro_pkg::OFS_INT_ENABLE)) begin
			ev_enable_q <= i_wdata[tro_pkg::EV_W-1:0];
		end else if (i_wr && (i_addr == tro_pkg::OFS_CONTROL2)) begin
			ctrl2_q <= i_wdata & tro_pkg::CTRL2_WRITE_MASK;
		end
	end

	assign o_irq = |(ev_status_q & ev_enable_q);

	assign al_hit = (i_addr >= tro_pkg::OFS_ALARM_BASE) && (i_addr <= tro_pkg::OFS_ALARM_LAST);
	assign al_ofs = 7'(i_addr - tro_pkg::OFS_ALARM_BASE);

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_q <= '0;
		end else if (i_rd) begin
			if (i_addr == tro_pkg::OFS_CUR_TEMP) begin
				rdata_q <= cur_temp_q;
			end else if (i_addr == tro_pkg::OFS_STATUS1) begin
				rdata_q <= 8'(ready_q) << tro_pkg::STATUS1_READY_BIT | 8'(i_mission_active) << tro_pkg::STATUS1_MISSION_BIT;
			end else if ((i_addr >= tro_pkg::OFS_CUR_ADC1) && (i_addr <= tro_pkg::OFS_CUR_ADC3)) begin
				rdata_q <= cur_adc_q[2'(i_addr - tro_pkg::OFS_CUR_ADC1)];
			end else if (i_addr == tro_pkg::OFS_CONTROL2) begin
				rdata_q <= ctrl2_q;
			end else if (i_addr == tro_pkg::OFS_INT_STATUS) begin
				rdata_q <= 8'(ev_status_q);
			end else if (i_addr == tro_pkg::OFS_INT_ENABLE) begin
				rdata_q <= 8'(ev_enable_q);
			end else if (al_hit) begin
				rdata_q <= alarm_q[al_ofs];
			end else if ((i_addr >= tro_pkg::OFS_HIST_BASE) && (i_addr <= tro_pkg::OFS_HIST_LAST)) begin
				rdata_q <= i_addr[0] ? hist_rd_data[15:8] : hist_rd_data[7:0];
			end else begin
				rdata_q <= '0;
			end
		end else begin
			rdata_q <= '0;
		end
	end

	assign o_rdata = rdata_q;
endmodule // tro_top
`default_nettype wire

// file: verif/tro_conv_model.sv
// Purpose: Behavioural temperature converter answering each start with one done pulse.
// Assumes: Starts never overlap; the bench sets the code before the start.
// Notes: Outside the done cycle the code lines show the inverse, so stale data cannot match.
`timescale 1ns/1ps
`default_nettype none
module tro_conv_model #(
	parameter int LAT = 6
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_start,
	input wire logic [7:0] i_code,
	output logic o_done,
	output logic [7:0] o_code
);
	logic [3:0] cnt_q;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q <= 4'h0;
			o_done <= 1'b0;
		end else begin
			cnt_q <= i_start ? 4'(LAT) : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
			o_done <= (cnt_q == 4'h1);
		end
	end
	assign o_code = o_done ? i_code : ~i_code;
endmodule // tro_conv_model
`default_nettype wire

// file: verif/tro_monitor.sv
// Purpose: Concurrent checks on conversion start, command handling and response order.
// Assumes: Single clock domain; sees only the top-level ports.
// Notes: Response checks assume the select bits stay put while a response is streaming.
`timescale 1ns/1ps
`default_nettype none
module tro_monitor (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_mission_active,
	input wire logic i_log_sample,
	input wire logic i_read_cmd,
	input wire logic o_temp_sensor_en,
	input wire logic o_temp_conv_start,
	input wire logic i_temp_conv_done,
	input wire tro_pkg::tro_resp_type o_resp,
	input wire logic i_resp_ready,
	input wire logic o_resp_last,
	input wire logic o_busy
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	a_sensor_gate: assert property (o_temp_conv_start |-> $past(o_temp_sensor_en))
		else $error("conversion started with the sensor off");
	a_cmd_start: assert property (i_read_cmd && !o_busy && !i_mission_active && o_temp_sensor_en
		|=> o_temp_conv_start) else $error("read command did not start a conversion");
	a_cmd_refused: assert property (i_read_cmd && i_mission_active && !i_log_sample
		|=> !o_temp_conv_start) else $error("read command converted during a mission");
	a_log_start: assert property (i_log_sample && !o_busy && i_mission_active && o_temp_sensor_en
		|=> o_temp_conv_start) else $error("logged sample did not start a conversion");
	a_start_busy: assert property (o_temp_conv_start |-> o_busy)
		else $error("conversion start while idle");
	a_temp_first: assert property ($rose(o_resp.valid) && o_temp_sensor_en |-> o_resp.channel == 2'd0)
		else $error("response did not begin with temperature");
	a_temp_skip: assert property (o_resp.valid |-> o_resp.channel != 2'd0 || o_temp_sensor_en)
		else $error("disabled temperature byte sent");
	a_done_resp: assert property (i_temp_conv_done && o_busy && !i_mission_active && o_temp_sensor_en
		|=> o_resp.valid && o_resp.channel == 2'd0) else $error("no response after command conversion");
	a_resp_hold: assert property (o_resp.valid && !i_resp_ready |=> o_resp.valid && $stable(o_resp))
		else $error("response changed while stalled");
	a_last_valid: assert property (o_resp_last |-> o_resp.valid)
		else $error("last flag without a byte");
	c_cmd: cover property (i_read_cmd && !o_busy && !i_mission_active);
	c_log: cover property (i_log_sample && i_mission_active && o_temp_sensor_en);
	c_stall: cover property (o_resp.valid && !i_resp_ready);
	c_last: cover property (o_resp_last && i_resp_ready);
endmodule // tro_monitor
bind tro_top tro_monitor u_mon (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_mission_active(i_mission_active), .i_log_sample(i_log_sample), .i_read_cmd(i_read_cmd),
	.o_temp_sensor_en(o_temp_sensor_en), .o_temp_conv_start(o_temp_conv_start),
	.i_temp_conv_done(i_temp_conv_done), .o_resp(o_resp), .i_resp_ready(i_resp_ready),
	.o_resp_last(o_resp_last), .o_busy(o_busy));
`default_nettype wire

// file: verif/temperature_readout_and_log_map_test.sv
// Purpose: Register-level tests of readout, data-ready, response order and log map.
// Assumes: Converter model answers six cycles after each start.
// Notes: Response ready toggles every cycle so every stream sees stalls.
`timescale 1ns/1ps
`default_nettype none
module temperature_readout_and_log_map_test;
	logic i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_resp_ready = 1'b0;
	logic i_mission_active = 1'b0, i_log_sample = 1'b0, i_read_cmd = 1'b0;
	logic [11:0] i_addr = 12'h000;
	logic [7:0] i_wdata = 8'h00, o_rdata, conv_code = 8'h00, code_w, ch_seq = 8'h00;
	logic o_temp_sensor_en, o_temp_conv_start, done_w, o_resp_last, o_busy, o_irq;
	tro_pkg::tro_adc_sample_type i_adc_sample = '0;
	tro_pkg::tro_alarm_rec_type i_alarm_rec = '0;
	tro_pkg::tro_resp_type o_resp;
	logic [31:0] w;
	logic [31:0] d_seq = 32'h0;
	logic [7:0] codes [3] = '{8'h32, 8'hfa, 8'hff};
	logic [7:0] adc_codes [2] = '{8'hfc, 8'h03};
	int n_mismatch = 0, total_checks = 0, n_bytes = 0, cyc = 0;
	always #2.5 i_clk = ~i_clk;
	tro_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_mission_active(i_mission_active), .i_log_sample(i_log_sample),
		.i_read_cmd(i_read_cmd), .o_temp_sensor_en(o_temp_sensor_en), .o_temp_conv_start(o_temp_conv_start),
		.i_temp_conv_done(done_w), .i_temp_code(code_w), .i_adc_sample(i_adc_sample),
		.i_alarm_rec(i_alarm_rec), .o_resp(o_resp), .i_resp_ready(i_resp_ready),
		.o_resp_last(o_resp_last), .o_busy(o_busy), .o_irq(o_irq));
	tro_conv_model #(.LAT(6)) u_conv (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(o_temp_conv_start),
		.i_code(conv_code), .o_done(done_w), .o_code(code_w));
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		i_resp_ready <= ~i_resp_ready;
		if (o_resp.valid === 1'b1 && i_resp_ready === 1'b1) begin
			ch_seq <= {ch_seq[5:0], o_resp.channel};
			d_seq <= {d_seq[23:0], o_resp.data};
			n_bytes <= n_bytes + 1;
		end
		if (cyc == 4000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [7:0] exp, input logic [7:0] m);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata & m, exp);
	endtask
	task pulse(input bit log);
		@(posedge i_clk);
		if (log) i_log_sample <= 1'b1;
		else i_read_cmd <= 1'b1;
		@(posedge i_clk);
		i_log_sample <= 1'b0;
		i_read_cmd <= 1'b0;
	endtask
	task wait_idle();
		#1;
		for (int k = 0; k < 60 && o_busy !== 1'b0; k++) @(posedge i_clk) #1;
		chk({7'h0, o_busy}, 8'h00);
	endtask
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1'b1;
		rd(tro_pkg::OFS_CUR_TEMP, 8'hff, 8'hff);
		rd(tro_pkg::OFS_CONTROL2, 8'h00, 8'hff);
		rd(12'h100, 8'h00, 8'hff);
		wr(tro_pkg::OFS_CONTROL2, 8'hff);
		rd(tro_pkg::OFS_CONTROL2, 8'h7e, 8'hff);
		wr(tro_pkg::OFS_INT_ENABLE, 8'h0f);
		for (int m = 0; m < 3; m++) begin
			conv_code <= codes[m];
			i_mission_active <= (m > 0);
			pulse(m > 0);
			rd(tro_pkg::OFS_STATUS1, 8'h00, 8'h80);
			wait_idle();
			rd(tro_pkg::OFS_CUR_TEMP, (m > 0) ? 8'hfa : 8'h32, 8'hff);
			rd(tro_pkg::OFS_STATUS1, 8'h80, 8'h80);
		end
		chk(ch_seq, 8'h1b);
		chk(d_seq[31:24], 8'h32);
		chk(8'(n_bytes), 8'h04);
		rd(12'h87c, 8'h02, 8'hff);
		rd(12'h87d, 8'h00, 8'hff);
		rd(tro_pkg::OFS_INT_STATUS, 8'h03, 8'h03);
		chk({7'h0, o_irq}, 8'h01);
		wr(tro_pkg::OFS_INT_ENABLE, 8'h00);
		#1 chk({7'h0, o_irq}, 8'h00);
		wr(tro_pkg::OFS_INT_CLEAR, 8'hff);
		rd(tro_pkg::OFS_INT_STATUS, 8'h00, 8'hff);
		wr(tro_pkg::OFS_INT_ENABLE, 8'h04);
		pulse(1'b0);
		#1 chk({7'h0, o_busy}, 8'h00);
		rd(tro_pkg::OFS_INT_STATUS, 8'h04, 8'h04);
		chk({7'h0, o_irq}, 8'h01);
		for (int j = 0; j < 2; j++) begin
			@(posedge i_clk);
			i_adc_sample <= '{valid: 1'b1, channel: 2'd1, code: adc_codes[j]};
			@(posedge i_clk);
			i_adc_sample.valid <= 1'b0;
			repeat (2) @(posedge i_clk);
			rd(tro_pkg::OFS_CUR_ADC1, adc_codes[j], 8'hff);
			rd(j ? 12'h880 : 12'h8fe, 8'h01, 8'hff);
		end
		for (int j = 0; j < 2; j++) begin
			w = {8'h9a - 8'(j), 24'h123456 + 24'(j)};
			@(posedge i_clk);
			i_alarm_rec <= '{valid: 1'b1, index: j ? 5'd0 : 5'd23, sample_count: w[23:0], duration: w[31:24]};
			@(posedge i_clk);
			i_alarm_rec.valid <= 1'b0;
			for (int b = 0; b < 4; b++) rd(12'h220 + (j ? 12'h0 : 12'h05c) + 12'(b), w[8*b +: 8], 8'hff);
		end
		wr(tro_pkg::OFS_CONTROL2, 8'h20);
		rd(tro_pkg::OFS_CUR_TEMP, 8'hff, 8'hff);
		chk({7'h0, o_temp_sensor_en}, 8'h00);
		i_mission_active <= 1'b0;
		pulse(1'b0);
		wait_idle();
		chk(ch_seq, 8'h6d);
		chk(d_seq[7:0], 8'h03);
		chk(8'(n_bytes), 8'h05);
		i_mission_active <= 1'b1;
		pulse(1'b1);
		repeat (10) @(posedge i_clk);
		rd(tro_pkg::OFS_CUR_TEMP, 8'hff, 8'hff);
		print_verdict();
	end
endmodule // temperature_readout_and_log_map_test
`default_nettype wire
